// *** design/sec_byte_store.sv ***
// Flip-flop byte storage with one write port and one indexed read port
`timescale 1ns/1ps
module sec_byte_store #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 256,
    parameter int AW = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_i,
    input wire logic [AW-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [AW-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
    } store_s;

    store_s q;
    store_s d;

    always_comb
    begin
        d = q;
        for (int i = 0; i < DEPTH; i++)
        begin
            if (wr_i && (waddr_i == AW'(i)))
            begin
                d.mem[i] = wdata_i;
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            q <= '0;
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    assign rdata_o = q.mem[raddr_i];
endmodule // sec_byte_store

// *** design/sec_copy_engine.sv ***
// Direct copy sequencer from the security TX FIFO toward the MAC TX FIFO
`timescale 1ns/1ps
`include "sec_fifo_params.svh"
module sec_copy_engine (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic abort_i,
    input wire sec_fifo_pkg::byte_t len_i,
    input wire logic data_avail_i,
    input wire logic mac_ready_i,
    output logic mac_valid_o,
    output logic pop_o,
    output logic busy_o
);
    import sec_fifo_pkg::*;

    copy_s q;
    copy_s d;

    always_comb
    begin
        d = q;
        case (q.state)
            COPY_IDLE:
            begin
                if (start_i && (len_i != `RST_BYTE) && !abort_i) // [RL13]
                begin
                    d.state = COPY_RUN;
                    d.remain = len_i;
                end
            end
            COPY_RUN:
            begin
                if (abort_i)
                begin
                    d.state = COPY_IDLE;
                    d.remain = `RST_BYTE;
                end
                else if (pop_o)
                begin
                    d.remain = q.remain - `CNT_ONE;
                    if (q.remain == `CNT_ONE)
                    begin
                        d.state = COPY_IDLE;
                    end
                end
            end
            default:
            begin
                d.state = COPY_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            q <= '{state: COPY_IDLE, remain: `RST_BYTE};
        end
        else if (ce_i)
        begin
            q <= d;
        end
    end

    assign busy_o = (q.state == COPY_RUN); // [RL14]
    assign mac_valid_o = busy_o && data_avail_i;
    assign pop_o = mac_valid_o && mac_ready_i;

    chk_busy_start: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL13]
        ce_i && !busy_o && start_i && !abort_i && (len_i != `RST_BYTE) |=> busy_o)
        else $error("copy did not start");

    chk_busy_ends: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RL14]
        ce_i && busy_o && pop_o && (q.remain == `CNT_ONE) |=> !busy_o)
        else $error("busy stayed after last byte");
endmodule // sec_copy_engine

// *** design/sec_fifo_params.svh ***
// Register offsets, field positions and reset values of the security FIFO block
`ifndef SEC_FIFO_PARAMS_SVH
`define SEC_FIFO_PARAMS_SVH

`define OFS_TX_PUSH 16'h2000
`define OFS_TX_WP 16'h2001
`define OFS_TX_RP 16'h2002
`define OFS_TX_CTRL 16'h2003
`define OFS_TX_STAT 16'h2004
`define OFS_TX_FILL 16'h2005
`define OFS_ENC_BASE 16'h2007
`define OFS_ENC_LEN 16'h2008
`define OFS_COPY_LEN 16'h2009
`define OFS_COPY_CTRL 16'h200A
`define OFS_RX_POP 16'h2080
`define OFS_RX_WP 16'h2081

`define MAP_SEL_ON 2'h1

`define CTRL_CLR_BIT 0
`define CTRL_EN_BIT 1
`define STAT_WP_MSB_BIT 7
`define STAT_RP_MSB_BIT 6
`define STAT_FULL_BIT 1
`define STAT_EMPTY_BIT 0
`define COPY_GO_BIT 0
`define COPY_BUSY_BIT 1

`define RST_BYTE 8'h00
`define RST_PTR 9'h000
`define RST_EN 1'b1
`define PTR_ONE 9'h001
`define CNT_ONE 8'h01

`endif

// *** design/sec_fifo_pkg.sv ***
// Types shared by the security FIFO modules
package sec_fifo_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [8:0] ptr_t;

    typedef enum logic [0:0] {
        COPY_IDLE = 1'b0,
        COPY_RUN = 1'b1
    } copy_state_e;

    typedef struct packed {
        copy_state_e state;
        byte_t remain;
    } copy_s;

    typedef struct packed {
        ptr_t wp;
        ptr_t rp;
        logic en;
        logic full;
        logic empty;
        byte_t fill;
        byte_t base;
        byte_t len;
        byte_t copy_len;
        ptr_t rx_wp;
        ptr_t rx_rp;
        byte_t rdata;
    } ctrl_s;

endpackage

// *** design/security_tx_fifo_ctrl.sv ***
// Security TX FIFO controller with direct copy and security RX pop port
// What this block does
// (RL1) TX write pointer is 9 bits, steps once per stored byte, resets zero.
// (RL2) TX read pointer is 9 bits, steps once per removed byte, resets zero.
// (RL3) Control bit 1 enables the TX FIFO; it resets to one.
// (RL4) Writing one to control bit 0 resets the TX pointers, status and fill count.
// (RL5) Status bit 7 is the write pointer top bit, writable, resets zero.
// (RL6) Status bit 6 is the read pointer top bit, writable, resets zero.
// (RL7) Status bit 1 reads one when the TX FIFO holds 256 bytes.
// (RL8) Status bit 0 reads one when the TX FIFO is empty; flags reset zero.
// (RL9) Fill count is write pointer minus read pointer.
// (RL10) Encryption frame base register, 8 bits, read/write, resets zero.
// (RL11) Encryption frame length register, 8 bits, read/write, resets zero.
// (RL12) Copy length register, 8 bits, read/write, resets zero.
// (RL13) Writing one to copy control bit 0 starts the copy to the MAC FIFO if the copy length is nonzero.
// (RL14) Copy control bit 1 reads one while the copy runs.
// (RL15) A push write stores the byte at the write pointer.
// (RL16) Reading the pop register returns the next security RX byte.
// (RL17) RX write pointer is 9 bits, steps once per stored byte, resets zero.
// (RL18) Registers respond only while the map select equals one.
// (RL19) Pushes into a full or disabled TX FIFO are dropped.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "sec_fifo_params.svh"
module security_tx_fifo_ctrl (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic [1:0] MAP_SEL_I,
    input wire logic [15:0] ADDR_I,
    input wire sec_fifo_pkg::byte_t WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output sec_fifo_pkg::byte_t RDATA_O,
    output sec_fifo_pkg::byte_t ENC_BASE_O,
    output sec_fifo_pkg::byte_t ENC_LEN_O,
    output logic TX_ENABLE_O,
    output logic COPY_BUSY_O,
    output logic MAC_VALID_O,
    input wire logic MAC_READY_I,
    output sec_fifo_pkg::byte_t MAC_DATA_O,
    input wire logic RX_WR_I,
    input wire sec_fifo_pkg::byte_t RX_DATA_I,
    output logic RX_READY_O
);
    import sec_fifo_pkg::*;

    ctrl_s q;
    ctrl_s d;

    logic sel;
    logic wr;
    logic rd;
    logic full_now;
    logic empty_now;
    logic rx_full_now;
    logic rx_empty_now;
    logic push;
    logic push_try;
    logic pop;
    logic rx_push;
    logic rx_pop;
    logic clr;
    logic copy_start;
    logic copy_busy;
    ptr_t diff;
    byte_t tx_rdata;
    byte_t rx_rdata;

    // Bus access only while the security map is selected
    assign sel = (MAP_SEL_I == `MAP_SEL_ON); // [RL18]
    assign wr = WR_I && sel;
    assign rd = RD_I && sel;

    assign diff = q.wp - q.rp;
    assign full_now = (q.wp[8] != q.rp[8]) && (q.wp[7:0] == q.rp[7:0]);
    assign empty_now = (q.wp == q.rp);
    assign rx_full_now = (q.rx_wp[8] != q.rx_rp[8]) && (q.rx_wp[7:0] == q.rx_rp[7:0]);
    assign rx_empty_now = (q.rx_wp == q.rx_rp);

    assign push_try = wr && (ADDR_I == `OFS_TX_PUSH);
    assign push = push_try && q.en && !full_now; // [RL19]
    assign clr = wr && (ADDR_I == `OFS_TX_CTRL) && WDATA_I[`CTRL_CLR_BIT];
    assign copy_start = wr && (ADDR_I == `OFS_COPY_CTRL) && WDATA_I[`COPY_GO_BIT];
    assign rx_push = RX_WR_I && !rx_full_now;
    assign rx_pop = rd && (ADDR_I == `OFS_RX_POP) && !rx_empty_now; // [RL16]

    sec_byte_store #(
        .WIDTH(8),
        .DEPTH(256),
        .AW(8)
    ) u_tx_store (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .wr_i(push), // [RL15]
        .waddr_i(q.wp[7:0]),
        .wdata_i(WDATA_I),
        .raddr_i(q.rp[7:0]),
        .rdata_o(tx_rdata)
    );

    sec_byte_store #(
        .WIDTH(8),
        .DEPTH(256),
        .AW(8)
    ) u_rx_store (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .wr_i(rx_push),
        .waddr_i(q.rx_wp[7:0]),
        .wdata_i(RX_DATA_I),
        .raddr_i(q.rx_rp[7:0]),
        .rdata_o(rx_rdata)
    );

    sec_copy_engine u_copy (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .start_i(copy_start),
        .abort_i(clr),
        .len_i(q.copy_len),
        .data_avail_i(!empty_now),
        .mac_ready_i(MAC_READY_I),
        .mac_valid_o(MAC_VALID_O),
        .pop_o(pop),
        .busy_o(copy_busy)
    );

    always_comb
    begin
        d = q;
        // Pointer stepping from the data paths
        if (push)
        begin
            d.wp = q.wp + `PTR_ONE; // [RL1]
        end
        if (pop)
        begin
            d.rp = q.rp + `PTR_ONE; // [RL2]
        end
        if (rx_push)
        begin
            d.rx_wp = q.rx_wp + `PTR_ONE; // [RL17]
        end
        if (rx_pop)
        begin
            d.rx_rp = q.rx_rp + `PTR_ONE;
        end
        // Flags and fill count follow the pointers one cycle later
        d.full = full_now; // [RL7]
        d.empty = empty_now; // [RL8]
        d.fill = diff[7:0]; // [RL9]
        // Software writes win over pointer stepping
        if (wr)
        begin
            if (ADDR_I == `OFS_TX_WP)
            begin
                d.wp[7:0] = WDATA_I;
            end
            else if (ADDR_I == `OFS_TX_RP)
            begin
                d.rp[7:0] = WDATA_I;
            end
            else if (ADDR_I == `OFS_TX_CTRL)
            begin
                d.en = WDATA_I[`CTRL_EN_BIT]; // [RL3]
            end
            else if (ADDR_I == `OFS_TX_STAT)
            begin
                d.wp[8] = WDATA_I[`STAT_WP_MSB_BIT]; // [RL5]
                d.rp[8] = WDATA_I[`STAT_RP_MSB_BIT]; // [RL6]
            end
            else if (ADDR_I == `OFS_ENC_BASE)
            begin
                d.base = WDATA_I; // [RL10]
            end
            else if (ADDR_I == `OFS_ENC_LEN)
            begin
                d.len = WDATA_I; // [RL11]
            end
            else if (ADDR_I == `OFS_COPY_LEN)
            begin
                d.copy_len = WDATA_I; // [RL12]
            end
            else if (ADDR_I == `OFS_RX_WP)
            begin
                d.rx_wp[7:0] = WDATA_I;
            end
        end
        // Clear overrides the TX pointers, flags and fill count
        if (clr)
        begin
            d.wp = `RST_PTR; // [RL4]
            d.rp = `RST_PTR;
            d.full = 1'b0;
            d.empty = 1'b0;
            d.fill = `RST_BYTE;
        end
        // Read data valid only in the cycle after the strobe
        d.rdata = `RST_BYTE;
        if (rd)
        begin
            if (ADDR_I == `OFS_TX_WP)
            begin
                d.rdata = q.wp[7:0];
            end
            else if (ADDR_I == `OFS_TX_RP)
            begin
                d.rdata = q.rp[7:0];
            end
            else if (ADDR_I == `OFS_TX_CTRL)
            begin
                d.rdata[`CTRL_EN_BIT] = q.en;
            end
            else if (ADDR_I == `OFS_TX_STAT)
            begin
                d.rdata[`STAT_WP_MSB_BIT] = q.wp[8]; // [RL5]
                d.rdata[`STAT_RP_MSB_BIT] = q.rp[8]; // [RL6]
                d.rdata[`STAT_FULL_BIT] = q.full;
                d.rdata[`STAT_EMPTY_BIT] = q.empty;
            end
            else if (ADDR_I == `OFS_TX_FILL)
            begin
                d.rdata = q.fill;
            end
            else if (ADDR_I == `OFS_ENC_BASE)
            begin
                d.rdata = q.base;
            end
            else if (ADDR_I == `OFS_ENC_LEN)
            begin
                d.rdata = q.len;
            end
            else if (ADDR_I == `OFS_COPY_LEN)
            begin
                d.rdata = q.copy_len;
            end
            else if (ADDR_I == `OFS_COPY_CTRL)
            begin
                d.rdata[`COPY_BUSY_BIT] = copy_busy; // [RL14]
            end
            else if (ADDR_I == `OFS_RX_POP)
            begin
                d.rdata = rx_empty_now ? `RST_BYTE : rx_rdata; // [RL16]
            end
            else if (ADDR_I == `OFS_RX_WP)
            begin
                d.rdata = q.rx_wp[7:0];
            end
        end
    end

    always_ff @(posedge CORE_CLK_I)
    begin
        if (!RST_N_I)
        begin
            q <= '0;
            q.en <= `RST_EN; // [RL3]
        end
        else if (CE_I)
        begin
            q <= d;
        end
    end

    assign RDATA_O = q.rdata;
    assign ENC_BASE_O = q.base;
    assign ENC_LEN_O = q.len;
    assign TX_ENABLE_O = q.en;
    assign COPY_BUSY_O = copy_busy;
    assign MAC_DATA_O = tx_rdata;
    assign RX_READY_O = !rx_full_now;

    // Helpers for the checks below
    logic wp_sw;
    logic rp_sw;
    assign wp_sw = wr && ((ADDR_I == `OFS_TX_WP) || (ADDR_I == `OFS_TX_STAT));
    assign rp_sw = wr && ((ADDR_I == `OFS_TX_RP) || (ADDR_I == `OFS_TX_STAT));

    chk_wp_step: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL1]
        CE_I && push && !wp_sw && !clr |=> q.wp == $past(q.wp) + `PTR_ONE)
        else $error("write pointer did not step");

    chk_rp_step: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL2]
        CE_I && pop && !rp_sw && !clr |=> q.rp == $past(q.rp) + `PTR_ONE)
        else $error("read pointer did not step");

    chk_enable_reset: assert property (@(posedge CORE_CLK_I) // [RL3]
        !RST_N_I |=> q.en)
        else $error("enable not set after reset");

    chk_clear_ptrs: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL4]
        CE_I && clr |=> (q.wp == `RST_PTR) && (q.rp == `RST_PTR) && !q.full && !q.empty
            && !COPY_BUSY_O)
        else $error("clear left state behind");

    chk_status_msbs: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL5]
        CE_I && rd && (ADDR_I == `OFS_TX_STAT) |=> (RDATA_O[`STAT_WP_MSB_BIT] == $past(q.wp[8]))
            && (RDATA_O[`STAT_RP_MSB_BIT] == $past(q.rp[8])))
        else $error("status top bits wrong");

    chk_full_flag: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL7]
        CE_I && !clr |=> q.full == ($past(diff) == 9'h100))
        else $error("full flag wrong");

    chk_empty_flag: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL8]
        CE_I && !clr |=> q.empty == ($past(diff) == `RST_PTR))
        else $error("empty flag wrong");

    chk_fill_count: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL9]
        CE_I && !clr ##1 CE_I && rd && (ADDR_I == `OFS_TX_FILL)
            |=> RDATA_O == $past(diff[7:0], 2))
        else $error("fill count wrong");

    chk_base_write: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL10]
        CE_I && wr && (ADDR_I == `OFS_ENC_BASE) |=> ENC_BASE_O == $past(WDATA_I))
        else $error("frame base not stored");

    chk_push_drop: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL19]
        CE_I && push_try && (full_now || !q.en) && !wp_sw && !clr |=> $stable(q.wp))
        else $error("dropped push moved pointer");

    chk_map_gate: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL18]
        CE_I && RD_I && !sel |=> RDATA_O == `RST_BYTE)
        else $error("read answered outside map");

    chk_rx_wp_step: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL17]
        CE_I && rx_push && !(wr && (ADDR_I == `OFS_RX_WP))
            |=> q.rx_wp == $past(q.rx_wp) + `PTR_ONE)
        else $error("rx write pointer did not step");

    chk_enable_write: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL3]
        CE_I && wr && (ADDR_I == `OFS_TX_CTRL) |=> TX_ENABLE_O == $past(WDATA_I[`CTRL_EN_BIT]))
        else $error("enable bit not stored");

    chk_len_write: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL11]
        CE_I && wr && (ADDR_I == `OFS_ENC_LEN) |=> ENC_LEN_O == $past(WDATA_I))
        else $error("frame length not stored");

    chk_copy_len_write: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL12]
        CE_I && wr && (ADDR_I == `OFS_COPY_LEN) |=> q.copy_len == $past(WDATA_I))
        else $error("copy length not stored");

    chk_rx_pop_step: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) // [RL16]
        CE_I && rx_pop |=> q.rx_rp == $past(q.rx_rp) + `PTR_ONE)
        else $error("rx read pointer did not step");
endmodule // security_tx_fifo_ctrl

// *** verif/mac_fifo_model.sv ***
// MAC transmit FIFO model taking bytes from the copy stream
`timescale 1ns/1ps
module mac_fifo_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic hold_i,
    input wire logic slow_i,
    input wire logic valid_i,
    input wire sec_fifo_pkg::byte_t data_i,
    output logic ready_o
);
    import sec_fifo_pkg::*;

    byte_t got [0:255];
    int n_got;
    logic phase_q;

    // Ready every cycle, every other cycle when slow, never when held
    always @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            phase_q <= 1'b0;
            ready_o <= 1'b0;
            n_got <= 0;
        end
        else
        begin
            phase_q <= ~phase_q;
            ready_o <= !hold_i && (!slow_i || phase_q);
            if (valid_i && ready_o)
            begin
                got[n_got] <= data_i;
                n_got <= n_got + 1;
            end
        end
    end
endmodule // mac_fifo_model

// *** verif/tb_top.sv ***
// Self-checking bench for the security TX FIFO controller
`timescale 1ns/1ps
`include "sec_fifo_params.svh"
module tb_top;
    import sec_fifo_pkg::*;

    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [1:0] map_sel = `MAP_SEL_ON;
    logic [15:0] addr = 16'h0000;
    byte_t wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    byte_t rdata, enc_base, enc_len, mac_data, rx_data = 8'h00;
    logic tx_en, busy, mac_valid, mac_ready, rx_wr = 1'b0, rx_ready;
    logic hold = 1'b1;
    logic slow = 1'b0;
    int miscompares = 0;
    int n_checks = 0;
    byte_t copy_bytes [0:2] = '{8'h3C, 8'h5A, 8'h96};

    always #5 core_clk = ~core_clk;

    security_tx_fifo_ctrl security_tx_fifo_ctrl_inst (
        .CORE_CLK_I(core_clk), .RST_N_I(rst_n), .CE_I(ce), .MAP_SEL_I(map_sel),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .ENC_BASE_O(enc_base), .ENC_LEN_O(enc_len), .TX_ENABLE_O(tx_en),
        .COPY_BUSY_O(busy), .MAC_VALID_O(mac_valid), .MAC_READY_I(mac_ready),
        .MAC_DATA_O(mac_data), .RX_WR_I(rx_wr), .RX_DATA_I(rx_data),
        .RX_READY_O(rx_ready)
    );

    mac_fifo_model mac_fifo_model_inst (
        .clk_i(core_clk), .rst_n_i(rst_n), .hold_i(hold), .slow_i(slow),
        .valid_i(mac_valid), .data_i(mac_data), .ready_o(mac_ready)
    );

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input byte_t d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        wdata <= ~d;
    endtask

    task automatic rd_reg(input logic [15:0] a, input byte_t exp);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, $sformatf("read of %h", a));
    endtask

    task automatic rx_push(input byte_t d);
        @(posedge core_clk);
        rx_wr <= 1'b1;
        rx_data <= d;
        #1;
        check({7'h00, rx_ready}, 8'h01, "rx ready");
        @(posedge core_clk);
        rx_wr <= 1'b0;
        rx_data <= ~d;
    endtask

    task automatic wait_idle();
        int i;
        i = 0;
        while (busy !== 1'b0 && i < 200)
        begin
            @(posedge core_clk);
            #1;
            i++;
        end
        check({7'h00, busy}, 8'h00, "copy finished");
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        miscompares++;
        $display("CHECK FAILED at %0t: run did not finish", $time);
        end_of_test();
    end

    initial
    begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        // Values out of reset
        rd_reg(`OFS_TX_WP, 8'h00);
        rd_reg(`OFS_TX_RP, 8'h00);
        rd_reg(`OFS_TX_CTRL, 8'h02);
        rd_reg(`OFS_TX_STAT, 8'h01);
        rd_reg(`OFS_TX_FILL, 8'h00);
        rd_reg(`OFS_COPY_CTRL, 8'h00);
        check({7'h00, tx_en}, 8'h01, "enable pin");
        // Plain read/write registers
        wr_reg(`OFS_ENC_BASE, 8'hA5);
        wr_reg(`OFS_ENC_LEN, 8'h5A);
        wr_reg(`OFS_COPY_LEN, 8'h03);
        rd_reg(`OFS_ENC_BASE, 8'hA5);
        rd_reg(`OFS_ENC_LEN, 8'h5A);
        rd_reg(`OFS_COPY_LEN, 8'h03);
        check(enc_base, 8'hA5, "base pin");
        check(enc_len, 8'h5A, "length pin");
        // Clock enable low freezes out a write
        ce <= 1'b0;
        wr_reg(`OFS_ENC_LEN, 8'h33);
        ce <= 1'b1;
        rd_reg(`OFS_ENC_LEN, 8'h5A);
        rd_reg(16'h2006, 8'h00);
        // Map select off: writes ignored, reads zero
        map_sel <= 2'h0;
        wr_reg(`OFS_ENC_BASE, 8'h11);
        rd_reg(`OFS_ENC_LEN, 8'h00);
        map_sel <= `MAP_SEL_ON;
        rd_reg(`OFS_ENC_BASE, 8'hA5);
        // Push three bytes
        foreach (copy_bytes[i])
            wr_reg(`OFS_TX_PUSH, copy_bytes[i]);
        rd_reg(`OFS_TX_WP, 8'h03);
        rd_reg(`OFS_TX_FILL, 8'h03);
        rd_reg(`OFS_TX_STAT, 8'h00);
        // Copy with the MAC side stalled, then slow
        wr_reg(`OFS_COPY_CTRL, 8'h01);
        rd_reg(`OFS_COPY_CTRL, 8'h02);
        check({7'h00, busy}, 8'h01, "busy pin");
        check({7'h00, mac_valid}, 8'h01, "valid while stalled");
        check(mac_data, copy_bytes[0], "first byte presented");
        hold <= 1'b0;
        slow <= 1'b1;
        wait_idle();
        check(mac_fifo_model_inst.n_got[7:0], 8'h03, "bytes copied");
        foreach (copy_bytes[i])
            check(mac_fifo_model_inst.got[i], copy_bytes[i], "copied byte");
        rd_reg(`OFS_TX_RP, 8'h03);
        rd_reg(`OFS_TX_STAT, 8'h01);
        rd_reg(`OFS_COPY_CTRL, 8'h00);
        // Clear, then fill to full and push once more
        wr_reg(`OFS_TX_CTRL, 8'h03);
        rd_reg(`OFS_TX_WP, 8'h00);
        rd_reg(`OFS_TX_RP, 8'h00);
        rd_reg(`OFS_TX_CTRL, 8'h02);
        for (int i = 0; i < 256; i++)
            wr_reg(`OFS_TX_PUSH, i[7:0]);
        rd_reg(`OFS_TX_STAT, 8'h82);
        rd_reg(`OFS_TX_FILL, 8'h00);
        wr_reg(`OFS_TX_PUSH, 8'hEE);
        rd_reg(`OFS_TX_WP, 8'h00);
        rd_reg(`OFS_TX_STAT, 8'h82);
        wr_reg(`OFS_TX_CTRL, 8'h03);
        rd_reg(`OFS_TX_STAT, 8'h01);
        rd_reg(`OFS_TX_FILL, 8'h00);
        // Disabled FIFO drops pushes
        wr_reg(`OFS_TX_CTRL, 8'h00);
        #1;
        check({7'h00, tx_en}, 8'h00, "enable pin");
        wr_reg(`OFS_TX_PUSH, 8'h77);
        rd_reg(`OFS_TX_WP, 8'h00);
        wr_reg(`OFS_TX_CTRL, 8'h02);
        // Pointer top bits written through status
        wr_reg(`OFS_TX_STAT, 8'hC3);
        rd_reg(`OFS_TX_STAT, 8'hC1);
        // Security RX FIFO: write side and pop
        rx_push(8'h11);
        rx_push(8'h22);
        rd_reg(`OFS_RX_WP, 8'h02);
        rd_reg(`OFS_RX_POP, 8'h11);
        rd_reg(`OFS_RX_POP, 8'h22);
        rd_reg(`OFS_RX_POP, 8'h00);
        end_of_test();
    end
endmodule // tb_top
